// ### bench/icirq_peer.sv
`timescale 1ns/100ps
module icirq_peer (
  output logic scl_out,
  output logic sda_out
);
  // released lines sit high on their pull-ups; scl stands still
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic start_cond;
    #75 sda_out = 1'b1;
    #75 scl_out = 1'b1;
    #100 sda_out = 1'b0;
    #100 scl_out = 1'b0;
    #200;
  endtask : start_cond
  // short high phase keeps sda three clocks clear of scl edges
  task automatic clocks(input int n);
    for (int i = 0; i < n; i++) begin
      #75 sda_out = ~sda_out;
      #75 scl_out = 1'b1;
      #50 scl_out = 1'b0;
    end
    #200;
  endtask : clocks
  task automatic stop_cond;
    #75 sda_out = 1'b0;
    #75 scl_out = 1'b1;
    #100 sda_out = 1'b1;
    #200;
  endtask : stop_cond
endmodule : icirq_peer

// ### bench/icirq_props.sv
`timescale 1ns/100ps
module icirq_props
  import icirq_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic                    CLK_IN,
  input wire logic                    SRST_IN,
  input wire logic                    PSEL_IN,
  input wire logic                    PENABLE_IN,
  input wire logic                    PWRITE_IN,
  input wire logic [ADDR_W-1:0]       PADDR_IN,
  input wire logic [icirq_pkg::DATA_W-1:0] PWDATA_IN,
  input wire logic [3:0]              PSTRB_IN,
  input wire logic [icirq_pkg::DATA_W-1:0] PRDATA_OUT,
  input wire logic                    PREADY_OUT,
  input wire logic                    PSLVERR_OUT,
  input wire logic                    IRQ_OUT,
  input wire logic [1:0]              IRQ_LEVEL_OUT,
  input wire logic                    RESTART_REQ_OUT,
  input wire logic                    NEXT_BYTE_OUT
);
  logic en_r;
  wire stp = PSEL_IN && !PENABLE_IN;
  wire acc = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PSTRB_IN[0];
  wire w1 = acc && PADDR_IN == ADDR_W'(OFS_CTRL_ONE);
  wire wc = acc && PADDR_IN == ADDR_W'(OFS_CLK_CTRL);
  wire wp = acc && PADDR_IN == ADDR_W'(OFS_PRIO);
  // enable is not visible at the ports, so keep a shadow of it
  always_ff @(posedge CLK_IN) begin
    en_r <= SRST_IN ? 1'b0 : (wc ? PWDATA_IN[BC_ENABLE] : en_r);
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SRST_IN);
  chk_ready_setup: assert property (stp |=> PREADY_OUT)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  chk_unmapped_err: assert property (
    stp && PADDR_IN > ADDR_W'(OFS_STATUS) |=> PSLVERR_OUT)
    else $error("unmapped access not refused");
  chk_vector_fields: assert property (
    stp && !PWRITE_IN && PADDR_IN == ADDR_W'(OFS_PRIO)
    |=> PRDATA_OUT[31:8] == {VECTOR_ADDR, VECTOR_NUM})
    else $error("vector fields wrong");
  chk_level_copy: assert property (
    wp |=> ##1 IRQ_LEVEL_OUT == $past(PWDATA_IN[1:0], 2))
    else $error("level output not updated");
  chk_restart_set: assert property (
    w1 && PWDATA_IN[B1_RESTART] && en_r |=> RESTART_REQ_OUT)
    else $error("restart request missing");
  chk_restart_first: assert property (
    w1 && PWDATA_IN[B1_RESTART] |=> !NEXT_BYTE_OUT)
    else $error("next byte despite restart");
  chk_next_cause: assert property (
    NEXT_BYTE_OUT |-> $past(w1 && !PWDATA_IN[B1_DONE_FLAG]))
    else $error("next byte without clear");
  chk_disable_clear: assert property (
    wc && !PWDATA_IN[BC_ENABLE] |=> !RESTART_REQ_OUT && !NEXT_BYTE_OUT)
    else $error("disable left restart set");
  chk_ones_keep: assert property (
    w1 && PWDATA_IN[3:0] == 4'hF && IRQ_OUT |=> IRQ_OUT [*2])
    else $error("writing ones dropped interrupt");
endmodule : icirq_props

// ### bench/icirq_top_bench.sv
`timescale 1ns/100ps
module icirq_top_bench;
  import icirq_pkg::*;
  logic        clk, rst, sel, en, we, tx, fb, bf, al, err;
  logic        rdy, serr, irq, rsq, nxb, scl, sda;
  logic [11:0] adr;
  logic [31:0] wd, rdat, rd;
  logic [3:0]  st;
  logic [1:0]  lvl;
  int          fail_count, n_checks;
  icirq_top icirq_top_i (
    .CLK_IN(clk), .SRST_IN(rst), .PSEL_IN(sel), .PENABLE_IN(en),
    .PWRITE_IN(we), .PADDR_IN(adr), .PWDATA_IN(wd), .PSTRB_IN(st),
    .SCL_IN(scl), .SDA_IN(sda), .TRANSMIT_DIR_BIT_IN(tx),
    .FIRST_BYTE_BIT_IN(fb), .BUS_FAULT_IN(bf), .ARB_LOST_IN(al),
    .PRDATA_OUT(rdat), .PREADY_OUT(rdy), .PSLVERR_OUT(serr),
    .IRQ_OUT(irq), .IRQ_LEVEL_OUT(lvl), .RESTART_REQ_OUT(rsq),
    .NEXT_BYTE_OUT(nxb));
  icirq_peer icirq_peer_i (.scl_out(scl), .sda_out(sda));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    sel <= 1'b1;
    en  <= 1'b0;
    we  <= w;
    adr <= a;
    wd  <= d;
    st  <= s;
    @(posedge clk);
    en <= 1'b1;
    n = 0;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n >= 16) fail_count++;
    rd = rdat;
    err = serr;
    sel <= 1'b0;
    en  <= 1'b0;
    // let the edge land so pulses of the next cycle are seen
    #1;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    xfer(1'b0, a, 32'h0, 4'hF);
    cmp(rd & m, e);
  endtask : rdc
  task automatic pulse(input bit f);
    @(posedge clk);
    if (f) bf <= 1'b1;
    else al <= 1'b1;
    @(posedge clk);
    bf <= 1'b0;
    al <= 1'b0;
  endtask : pulse
  task automatic close_out;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    sel = 1'b0;
    en  = 1'b0;
    we  = 1'b0;
    tx  = 1'b0;
    fb  = 1'b0;
    bf  = 1'b0;
    al  = 1'b0;
    adr = 12'h0;
    wd  = 32'h0;
    st  = 4'hF;
    fail_count = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp(32'(lvl), 32'h3);
    rdc(OFS_PRIO, 32'hFFDA1003, 32'hFFFFFFFF);
    xfer(1'b0, 12'h014, 32'h0, 4'hF);
    cmp(32'(err), 32'h1);
    wr(OFS_CLK_CTRL, 32'h1);
    wr(OFS_PRIO, 32'h1);
    cmp(32'(lvl), 32'h1);
    wr(OFS_CTRL_ZERO, 32'h20);
    icirq_peer_i.start_cond();
    rdc(OFS_CTRL_ZERO, 32'h30, 32'h7F);
    cmp(32'(irq), 32'h1);
    wr(OFS_CTRL_ZERO, 32'h30);
    rdc(OFS_CTRL_ZERO, 32'h30, 32'h7F);
    wr(OFS_CTRL_ZERO, 32'h20);
    rdc(OFS_CTRL_ZERO, 32'h20, 32'h7F);
    cmp(32'(irq), 32'h0);
    wr(OFS_CTRL_ONE, 32'h10);
    cmp(32'(rsq), 32'h1);
    wr(OFS_CTRL_ZERO, 32'h40);
    icirq_peer_i.start_cond();
    cmp(32'(rsq), 32'h0);
    icirq_peer_i.clocks(8);
    rdc(OFS_CTRL_ONE, 32'h1, 32'h3);
    cmp(32'(irq), 32'h0);
    icirq_peer_i.clocks(1);
    wr(OFS_CTRL_ONE, 32'h3);
    cmp(32'(irq), 32'h1);
    wr(OFS_CTRL_ONE, 32'h2);
    cmp(32'(nxb), 32'h1);
    cmp(32'(irq), 32'h0);
    wr(OFS_CTRL_ZERO, 32'h0);
    icirq_peer_i.clocks(8);
    rdc(OFS_CTRL_ONE, 32'h2, 32'h3);
    icirq_peer_i.clocks(1);
    rdc(OFS_CTRL_ONE, 32'h3, 32'h3);
    wr(OFS_CTRL_ONE, 32'h12);
    cmp(32'(nxb), 32'h0);
    cmp(32'(rsq), 32'h1);
    icirq_peer_i.start_cond();
    @(posedge clk);
    fb <= 1'b1;
    wr(OFS_CTRL_ZERO, 32'h40);
    rdc(OFS_STATUS, 32'h2, 32'h3);
    icirq_peer_i.clocks(8);
    rdc(OFS_CTRL_ONE, 32'h2, 32'h3);
    icirq_peer_i.clocks(1);
    rdc(OFS_CTRL_ONE, 32'h3, 32'h3);
    wr(OFS_CTRL_ONE, 32'h0);
    // transmit direction also forces the ninth cycle
    @(posedge clk);
    fb <= 1'b0;
    tx <= 1'b1;
    rdc(OFS_STATUS, 32'h1, 32'h3);
    icirq_peer_i.clocks(8);
    rdc(OFS_CTRL_ONE, 32'h0, 32'h1);
    icirq_peer_i.clocks(1);
    rdc(OFS_CTRL_ONE, 32'h1, 32'h1);
    wr(OFS_CTRL_ONE, 32'h0);
    pulse(1'b1);
    rdc(OFS_CTRL_ONE, 32'h4, 32'hF);
    cmp(32'(irq), 32'h0);
    wr(OFS_CTRL_ONE, 32'hF);
    wr(OFS_CTRL_ONE, 32'hF);
    rdc(OFS_CTRL_ONE, 32'hE, 32'hF);
    cmp(32'(irq), 32'h1);
    wr(OFS_CTRL_ONE, 32'hA);
    cmp(32'(irq), 32'h0);
    wr(OFS_CTRL_ZERO, 32'h8);
    pulse(1'b0);
    rdc(OFS_CTRL_ZERO, 32'hC, 32'hC);
    cmp(32'(irq), 32'h1);
    wr(OFS_CTRL_ZERO, 32'h8);
    cmp(32'(irq), 32'h0);
    wr(OFS_CTRL_ZERO, 32'h2);
    icirq_peer_i.stop_cond();
    rdc(OFS_CTRL_ZERO, 32'h3, 32'h3);
    cmp(32'(irq), 32'h1);
    wr(OFS_CTRL_ZERO, 32'h2);
    cmp(32'(irq), 32'h0);
    xfer(1'b1, OFS_CLK_CTRL, 32'h0, 4'h0);
    rdc(OFS_CLK_CTRL, 32'h1, 32'h1);
    pulse(1'b1);
    wr(OFS_CTRL_ZERO, 32'h60);
    wr(OFS_CTRL_ONE, 32'h1E);
    wr(OFS_CLK_CTRL, 32'h0);
    cmp(32'(rsq), 32'h0);
    rdc(OFS_CTRL_ONE, 32'hC, 32'h1F);
    rdc(OFS_CTRL_ZERO, 32'h0, 32'h70);
    cmp(32'(irq), 32'h1);
    close_out();
  end
endmodule : icirq_top_bench
bind icirq_top icirq_props #(.ADDR_W(ADDR_W)) icirq_props_i (
  .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT),
  .IRQ_LEVEL_OUT(IRQ_LEVEL_OUT), .RESTART_REQ_OUT(RESTART_REQ_OUT),
  .NEXT_BYTE_OUT(NEXT_BYTE_OUT));

// ### logic/icirq_bus_mon.sv
`timescale 1ns/100ps
module icirq_bus_mon (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic enable_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      start_out,
  output logic      stop_out,
  output logic      eighth_out,
  output logic      ninth_out,
  output logic      busy_out,
  output logic [3:0] bit_cnt_out
);
  import icirq_pkg::*;

  icirq_mon_type r_r;
  icirq_mon_type r_nxt;
  logic          scl_hi;

  always_comb begin
    r_nxt = r_r;
    r_nxt.scl_s1   = scl_in;
    r_nxt.scl_s2   = r_r.scl_s1;
    r_nxt.scl_d    = r_r.scl_s2;
    r_nxt.sda_s1   = sda_in;
    r_nxt.sda_s2   = r_r.sda_s1;
    r_nxt.sda_d    = r_r.sda_s2;
    r_nxt.start_p  = 1'b0;
    r_nxt.stop_p   = 1'b0;
    r_nxt.eighth_p = 1'b0;
    r_nxt.ninth_p  = 1'b0;
    // sda edges only count while scl stays high across both samples
    scl_hi = r_r.scl_s2 & r_r.scl_d;
    if (!enable_in) begin
      r_nxt.busy    = 1'b0;
      r_nxt.bit_cnt = 4'h0;
    end else if (scl_hi && r_r.sda_d && !r_r.sda_s2) begin
      r_nxt.start_p = 1'b1;
      r_nxt.busy    = 1'b1;
      r_nxt.bit_cnt = 4'h0;
    end else if (scl_hi && !r_r.sda_d && r_r.sda_s2) begin
      r_nxt.stop_p  = 1'b1;
      r_nxt.busy    = 1'b0;
      r_nxt.bit_cnt = 4'h0;
    end else if (r_r.busy && r_r.scl_s2 && !r_r.scl_d) begin
      r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
    end else if (r_r.busy && !r_r.scl_s2 && r_r.scl_d) begin
      if (r_r.bit_cnt == BIT_EIGHTH) begin
        r_nxt.eighth_p = 1'b1;
      end else if (r_r.bit_cnt == BIT_NINTH) begin
        r_nxt.ninth_p = 1'b1;
        r_nxt.bit_cnt = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r_r <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
               sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign start_out   = r_r.start_p;
  assign stop_out    = r_r.stop_p;
  assign eighth_out  = r_r.eighth_p;
  assign ninth_out   = r_r.ninth_p;
  assign busy_out    = r_r.busy;
  assign bit_cnt_out = r_r.bit_cnt;

endmodule : icirq_bus_mon

// ### logic/icirq_pkg.sv
// What this block does
// RULE_01: writing one to restart_gen_bit requests a start condition on the bus
// RULE_02: with done_timing_sel zero, completion flag rises in the ninth SCL cycle
// RULE_03: with done_timing_sel one, completion flag rises in the eighth SCL cycle
// RULE_04: channel interrupt uses one level register, vector sixteen at FFDA
// RULE_05: transfer completion request passes only while xfer_done_irq_en is one
// RULE_06: writing zero to the completion flag clears its pending request
// RULE_07: bus fault request gated by its enable, cleared by writing zero
// RULE_08: stop condition sets stop_seen_flag, gated by enable, cleared by zero
// RULE_09: arbitration loss sets arb_lost_flag, gated by enable, cleared by zero
// RULE_10: start condition sets start_seen_flag, gated by enable, zero clears it
// RULE_11: timing select only for reception, not first byte; else ninth cycle
// RULE_12: restart written with completion clear beats the next byte transfer
// RULE_13: disable clears most control bits and status, keeping bus fault pair; code also keeps stop_en and arb_en
// RULE_14: interrupt line high while any flag and its enable are both set
// RULE_15: writing one to a zero-clear flag leaves that flag unchanged
package icirq_pkg;

  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL_ONE  = 12'h000;
  localparam logic [11:0] OFS_CTRL_ZERO = 12'h004;
  localparam logic [11:0] OFS_CLK_CTRL  = 12'h008;
  localparam logic [11:0] OFS_PRIO      = 12'h00C;
  localparam logic [11:0] OFS_STATUS    = 12'h010;

  // bus_ctrl_reg_one fields
  localparam int B1_DONE_FLAG  = 0;
  localparam int B1_DONE_EN    = 1;
  localparam int B1_FAULT_FLAG = 2;
  localparam int B1_FAULT_EN   = 3;
  localparam int B1_RESTART    = 4;

  // bus_ctrl_reg_zero fields
  localparam int B0_STOP_FLAG  = 0;
  localparam int B0_STOP_EN    = 1;
  localparam int B0_ARB_FLAG   = 2;
  localparam int B0_ARB_EN     = 3;
  localparam int B0_START_FLAG = 4;
  localparam int B0_START_EN   = 5;
  localparam int B0_TIMING_SEL = 6;

  // clock_ctrl_reg and irq_priority_reg fields
  localparam int BC_ENABLE     = 0;
  localparam int BP_LEVEL_LSB  = 0;
  localparam int BP_VEC_NUM    = 8;
  localparam int BP_VEC_ADDR   = 16;

  // status fields
  localparam int BS_TX_DIR     = 0;
  localparam int BS_FIRST_BYTE = 1;
  localparam int BS_BUSY       = 2;
  localparam int BS_BIT_CNT    = 4;

  // interrupt channel identity
  localparam logic [19:0] LEVEL_REG_ADDR = 20'h0007D;
  localparam logic [7:0]  VECTOR_NUM     = 8'h10;
  localparam logic [15:0] VECTOR_ADDR    = 16'hFFDA;

  // reset values
  localparam logic [1:0]  RST_LEVEL      = 2'h3;
  localparam logic        RST_ENABLE     = 1'b0;

  // scl cycle numbers that end a byte
  localparam logic [3:0]  BIT_EIGHTH     = 4'h8;
  localparam logic [3:0]  BIT_NINTH      = 4'h9;

  typedef enum {
    SEL_NONE, SEL_CTRL_ONE, SEL_CTRL_ZERO, SEL_CLK_CTRL, SEL_PRIO, SEL_STATUS
  } icirq_sel_type;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_d;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_d;
    logic       busy;
    logic [3:0] bit_cnt;
    logic       start_p;
    logic       stop_p;
    logic       eighth_p;
    logic       ninth_p;
  } icirq_mon_type;

  typedef struct packed {
    logic              done_flag;
    logic              done_en;
    logic              fault_flag;
    logic              fault_en;
    logic              restart;
    logic              stop_flag;
    logic              stop_en;
    logic              arb_flag;
    logic              arb_en;
    logic              start_flag;
    logic              start_en;
    logic              timing_sel;
    logic              if_enable;
    logic [1:0]        level;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic              next_byte;
  } icirq_state_type;

endpackage : icirq_pkg

// ### logic/icirq_top.sv
`timescale 1ns/100ps
module icirq_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic                         CLK_IN,
  input  wire logic                         SRST_IN,
  input  wire logic                         PSEL_IN,
  input  wire logic                         PENABLE_IN,
  input  wire logic                         PWRITE_IN,
  input  wire logic [ADDR_W-1:0]            PADDR_IN,
  input  wire logic [icirq_pkg::DATA_W-1:0] PWDATA_IN,
  input  wire logic [3:0]                   PSTRB_IN,
  input  wire logic                         SCL_IN,
  input  wire logic                         SDA_IN,
  input  wire logic                         TRANSMIT_DIR_BIT_IN,
  input  wire logic                         FIRST_BYTE_BIT_IN,
  input  wire logic                         BUS_FAULT_IN,
  input  wire logic                         ARB_LOST_IN,
  output logic [icirq_pkg::DATA_W-1:0]      PRDATA_OUT,
  output logic                              PREADY_OUT,
  output logic                              PSLVERR_OUT,
  output logic                              IRQ_OUT,
  output logic [1:0]                        IRQ_LEVEL_OUT,
  output logic                              RESTART_REQ_OUT,
  output logic                              NEXT_BYTE_OUT
);
  import icirq_pkg::*;

  if (ADDR_W < 5) begin : g_addr_check
    $error("ADDR_W too narrow for the register map");
  end

  icirq_state_type r_r;
  icirq_state_type r_nxt;

  logic            mon_start;
  logic            mon_stop;
  logic            mon_eighth;
  logic            mon_ninth;
  logic            mon_busy;
  logic [3:0]      mon_bit_cnt;

  logic            setup_phase;
  logic            wr_take;
  icirq_sel_type   rd_sel;
  icirq_sel_type   wr_sel;
  logic            reception;
  logic            done_event;
  logic            fault_event;
  logic            arb_event;
  logic            stop_event;
  logic            start_event;
  logic            restart_wr;
  logic            done_clr_wr;

  function automatic icirq_sel_type decode(input logic [ADDR_W-1:0] addr);
    logic [11:0] a;
    a = 12'(addr);
    if (ADDR_W > 12 && (addr >> 12) != '0) begin
      decode = SEL_NONE;
    end else if (a == OFS_CTRL_ONE) begin
      decode = SEL_CTRL_ONE;
    end else if (a == OFS_CTRL_ZERO) begin
      decode = SEL_CTRL_ZERO;
    end else if (a == OFS_CLK_CTRL) begin
      decode = SEL_CLK_CTRL;
    end else if (a == OFS_PRIO) begin
      decode = SEL_PRIO;
    end else if (a == OFS_STATUS) begin
      decode = SEL_STATUS;
    end else begin
      decode = SEL_NONE;
    end
  endfunction : decode

  function automatic logic any_request(input icirq_state_type s);
    any_request = (s.done_flag  & s.done_en)  |
                  (s.fault_flag & s.fault_en) |
                  (s.stop_flag  & s.stop_en)  |
                  (s.arb_flag   & s.arb_en)   |
                  (s.start_flag & s.start_en);
  endfunction : any_request

  function automatic logic [DATA_W-1:0] read_word(
    input icirq_sel_type   sel,
    input icirq_state_type s,
    input logic            tx_dir,
    input logic            first_byte,
    input logic            busy,
    input logic [3:0]      bit_cnt
  );
    logic [DATA_W-1:0] w;
    w = '0;
    case (sel)
      SEL_CTRL_ONE: begin
        w[B1_DONE_FLAG]  = s.done_flag;
        w[B1_DONE_EN]    = s.done_en;
        w[B1_FAULT_FLAG] = s.fault_flag;
        w[B1_FAULT_EN]   = s.fault_en;
        w[B1_RESTART]    = s.restart;
      end
      SEL_CTRL_ZERO: begin
        w[B0_STOP_FLAG]  = s.stop_flag;
        w[B0_STOP_EN]    = s.stop_en;
        w[B0_ARB_FLAG]   = s.arb_flag;
        w[B0_ARB_EN]     = s.arb_en;
        w[B0_START_FLAG] = s.start_flag;
        w[B0_START_EN]   = s.start_en;
        w[B0_TIMING_SEL] = s.timing_sel;
      end
      SEL_CLK_CTRL: begin
        w[BC_ENABLE] = s.if_enable;
      end
      SEL_PRIO: begin
        w[BP_LEVEL_LSB+:2] = s.level;
        w[BP_VEC_NUM+:8]   = VECTOR_NUM;  // RULE_04
        w[BP_VEC_ADDR+:16] = VECTOR_ADDR; // RULE_04
      end
      SEL_STATUS: begin
        w[BS_TX_DIR]       = tx_dir;
        w[BS_FIRST_BYTE]   = first_byte;
        w[BS_BUSY]         = busy;
        w[BS_BIT_CNT+:4]   = bit_cnt;
      end
      default: begin
        w = '0;
      end
    endcase
    read_word = w;
  endfunction : read_word

  icirq_bus_mon u_bus_mon (
    .clk_in      (CLK_IN),
    .srst_in     (SRST_IN),
    .enable_in   (r_r.if_enable),
    .scl_in      (SCL_IN),
    .sda_in      (SDA_IN),
    .start_out   (mon_start),
    .stop_out    (mon_stop),
    .eighth_out  (mon_eighth),
    .ninth_out   (mon_ninth),
    .busy_out    (mon_busy),
    .bit_cnt_out (mon_bit_cnt)
  );

  always_comb begin
    r_nxt       = r_r;
    r_nxt.pready    = 1'b0;
    r_nxt.pslverr   = 1'b0;
    r_nxt.next_byte = 1'b0;

    // apb: ready is registered, so every transfer has one access cycle
    setup_phase = PSEL_IN & ~PENABLE_IN;
    wr_take     = PSEL_IN & PENABLE_IN & r_r.pready & PWRITE_IN;
    rd_sel      = decode(PADDR_IN);
    wr_sel      = wr_take ? decode(PADDR_IN) : SEL_NONE;
    if (setup_phase) begin
      r_nxt.pready  = 1'b1;
      r_nxt.pslverr = (rd_sel == SEL_NONE);
      r_nxt.prdata  = PWRITE_IN ? '0 :
                      read_word(rd_sel, r_r, TRANSMIT_DIR_BIT_IN,
                                FIRST_BYTE_BIT_IN, mon_busy, mon_bit_cnt);
    end

    // bus events, ignored while the interface is off
    reception   = ~TRANSMIT_DIR_BIT_IN & ~FIRST_BYTE_BIT_IN;
    done_event  = r_r.if_enable &
                  ((mon_eighth & reception & r_r.timing_sel) | // RULE_03
                   (mon_ninth & ~(reception & r_r.timing_sel))); // RULE_02 RULE_11
    fault_event = r_r.if_enable & BUS_FAULT_IN;
    arb_event   = r_r.if_enable & ARB_LOST_IN;
    stop_event  = r_r.if_enable & mon_stop;
    start_event = r_r.if_enable & mon_start;

    restart_wr  = 1'b0;
    done_clr_wr = 1'b0;

    if (wr_sel == SEL_CTRL_ONE && PSTRB_IN[0]) begin
      r_nxt.done_en  = PWDATA_IN[B1_DONE_EN];
      r_nxt.fault_en = PWDATA_IN[B1_FAULT_EN];
      // writing one keeps a flag, zero clears it
      if (!PWDATA_IN[B1_DONE_FLAG]) begin // RULE_15
        r_nxt.done_flag = 1'b0; // RULE_06
        done_clr_wr     = r_r.done_flag;
      end
      if (!PWDATA_IN[B1_FAULT_FLAG]) begin // RULE_15
        r_nxt.fault_flag = 1'b0; // RULE_07
      end
      if (PWDATA_IN[B1_RESTART]) begin
        r_nxt.restart = 1'b1; // RULE_01
        restart_wr    = 1'b1;
      end
    end else if (wr_sel == SEL_CTRL_ZERO && PSTRB_IN[0]) begin
      r_nxt.stop_en    = PWDATA_IN[B0_STOP_EN];
      r_nxt.arb_en     = PWDATA_IN[B0_ARB_EN];
      r_nxt.start_en   = PWDATA_IN[B0_START_EN];
      r_nxt.timing_sel = PWDATA_IN[B0_TIMING_SEL];
      if (!PWDATA_IN[B0_STOP_FLAG]) begin // RULE_15
        r_nxt.stop_flag = 1'b0; // RULE_08
      end
      if (!PWDATA_IN[B0_ARB_FLAG]) begin // RULE_15
        r_nxt.arb_flag = 1'b0; // RULE_09
      end
      if (!PWDATA_IN[B0_START_FLAG]) begin // RULE_15
        r_nxt.start_flag = 1'b0; // RULE_10
      end
    end else if (wr_sel == SEL_CLK_CTRL && PSTRB_IN[0]) begin
      r_nxt.if_enable = PWDATA_IN[BC_ENABLE];
    end else if (wr_sel == SEL_PRIO && PSTRB_IN[0]) begin
      r_nxt.level = PWDATA_IN[BP_LEVEL_LSB+:2]; // RULE_04
    end

    // releasing the completion flag lets the core move on, unless a
    // restart arrives in the same write and wins
    if (done_clr_wr && !restart_wr) begin // RULE_12
      r_nxt.next_byte = 1'b1;
    end

    // restart request drops once the start is seen on the wires
    if (start_event && !restart_wr) begin
      r_nxt.restart = 1'b0;
    end

    // events set after clears so a coincident clear cannot lose one
    if (done_event) begin
      r_nxt.done_flag = 1'b1;
    end
    if (fault_event) begin
      r_nxt.fault_flag = 1'b1;
    end
    if (stop_event) begin
      r_nxt.stop_flag = 1'b1; // RULE_08
    end
    if (arb_event) begin
      r_nxt.arb_flag = 1'b1; // RULE_09
    end
    if (start_event) begin
      r_nxt.start_flag = 1'b1; // RULE_10
    end

    // interface off: bus fault pair survives so a fault is not hidden
    if (!r_nxt.if_enable) begin // RULE_13
      r_nxt.start_en   = 1'b0;
      r_nxt.timing_sel = 1'b0;
      r_nxt.done_flag  = 1'b0;
      r_nxt.done_en    = 1'b0;
      r_nxt.restart    = 1'b0;
      r_nxt.stop_flag  = 1'b0;
      r_nxt.arb_flag   = 1'b0;
      r_nxt.start_flag = 1'b0;
      r_nxt.next_byte  = 1'b0;
    end

    // each flag reaches the line only through its enable
    r_nxt.irq = any_request(r_nxt); // RULE_05 RULE_07 RULE_14
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      r_r           <= '0;
      r_r.level     <= RST_LEVEL;
      r_r.if_enable <= RST_ENABLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign PRDATA_OUT      = r_r.prdata;
  assign PREADY_OUT      = r_r.pready;
  assign PSLVERR_OUT     = r_r.pslverr;
  assign IRQ_OUT         = r_r.irq;
  assign IRQ_LEVEL_OUT   = r_r.level;
  assign RESTART_REQ_OUT = r_r.restart;
  assign NEXT_BYTE_OUT   = r_r.next_byte;

endmodule : icirq_top
